//--- src/nis_pkg.sv
// Package: register map, field layout and shared types of the NFC status register bank
package nis_pkg;

  localparam logic [7:0] NIS_OFS_MAIN_IRQ = 8'h1a;
  localparam logic [7:0] NIS_OFS_TIMER_FIELD = 8'h1b;
  localparam logic [7:0] NIS_OFS_ERR_WAKE = 8'h1c;
  localparam logic [7:0] NIS_OFS_PT_IRQ = 8'h1d;
  localparam logic [7:0] NIS_OFS_FILL_LOW = 8'h1e;
  localparam logic [7:0] NIS_OFS_FILL_HIGH = 8'h1f;
  localparam logic [7:0] NIS_OFS_COLLISION = 8'h20;
  localparam logic [7:0] NIS_OFS_TARGET_STATE = 8'h21;
  localparam logic [7:0] NIS_OFS_TX_LEN_HIGH = 8'h22;
  localparam logic [7:0] NIS_OFS_TX_LEN_LOW = 8'h23;
  localparam logic [7:0] NIS_OFS_BITRATE_TIMER = 8'h24;
  localparam logic [7:0] NIS_OFS_CONVERTER = 8'h25;
  localparam logic [7:0] NIS_OFS_TUNE_A = 8'h26;
  localparam logic [7:0] NIS_OFS_TUNE_B = 8'h27;
  localparam logic [7:0] NIS_OFS_TX_DRIVER = 8'h28;

  localparam logic [7:0] NIS_RST_TUNE_A = 8'h80;
  localparam logic [7:0] NIS_RST_TUNE_B = 8'h80;
  localparam logic [7:0] NIS_RST_TX_DRIVER = 8'h70;
  localparam logic [7:0] NIS_RST_TX_LEN = 8'h00;

  localparam int NIS_FILL_MAX = 512;
  localparam int NIS_TX_LEN_MAX = 8191;

  // Event strobes from the protocol core, one-cycle pulses
  typedef struct packed {
    logic direct_cmd_done;
    logic no_response_expired;
    logic general_timer_expired;
    logic field_on;
    logic field_off;
    logic collision_in_avoidance;
    logic guard_time_done;
    logic bitrate_recognised;
    logic crc_error;
    logic parity_error;
    logic soft_framing_irq;
    logic hard_framing_irq;
    logic wakeup_timer_irq;
    logic amplitude_wake;
    logic phase_wake;
    logic peer_wait_timeout_irq;
    logic slot_pool_low_irq;
    logic active_field_on;
    logic auto_response_sent;
    logic f_target_active_irq;
    logic a_target_active_star_irq;
    logic a_target_active_irq;
  } nis_events_t;

  // Live status levels from the core
  typedef struct packed {
    logic [9:0] fill_count;
    logic fill_underflow;
    logic fill_overflow;
    logic [2:0] partial_byte_bits;
    logic last_byte_parity_missing;
    logic collision_valid;
    logic [3:0] collision_bytes;
    logic [2:0] collision_bits;
    logic collision_in_parity;
    logic [3:0] target_state;
    logic [1:0] bitrate_code;
    logic peer_field_wait_running;
    logic general_timer_running;
    logic no_response_running;
    logic mask_receive_running;
    logic [7:0] converter_value;
  } nis_status_t;

  // Host-written settings handed to the core
  typedef struct packed {
    logic [12:0] tx_full_bytes;
    logic [2:0] tx_extra_bits;
    logic [7:0] tuning_a;
    logic [7:0] tuning_b;
    logic [7:0] tx_driver;
  } nis_config_t;

  typedef enum logic [3:0] {
    NIS_PT_POWER_OFF = 4'b0000,
    NIS_PT_IDLE = 4'b0001,
    NIS_PT_READY_L1 = 4'b0010,
    NIS_PT_READY_L2 = 4'b0011,
    NIS_PT_ACTIVE = 4'b0101,
    NIS_PT_HALT = 4'b1001,
    NIS_PT_READY_L1_STAR = 4'b1010,
    NIS_PT_READY_L2_STAR = 4'b1011,
    NIS_PT_ACTIVE_STAR = 4'b1101
  } nis_pt_state_t;

endpackage : nis_pkg

//--- src/nis_flag_reg.sv
// Sticky 8-bit flag register with clear-on-read, set winning over clear
`timescale 1ns/1ps
module nis_flag_reg
  import nis_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic clear,
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } nis_flag_state_t;

  nis_flag_state_t state_q;
  nis_flag_state_t state_d;

  initial begin
    if (WIDTH < 1) begin
      $error("nis_flag_reg: WIDTH must be at least 1");
    end
  end

  always_comb begin
    state_d = state_q;
    if (clear) begin
      state_d.flags = '0;
    end
    // Event in the clearing cycle survives
    state_d.flags = state_d.flags | set_bits;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flags;

endmodule : nis_flag_reg

//--- src/nis_status_regs.sv
// NFC front end interrupt, status and display registers on an Avalon-MM slave
// Behaviour
// - Reading timer/field and target flags clears them
// - Main interrupt read clears error/wake-up flags
// - Bits 5,4,3: timer expiry, field on, off
// - Bit 1 guard time done, bit 2 collision
// - Error bits: CRC, parity, soft, hard framing
// - Wake-up bits: timer 3, amplitude 2, phase 1
// - Bit 6: only four free slot numbers
// - Bit 5 active field on, bit 7 timeout
// - Bit 4: automatic anticollision response sent
// - Bits 3,1,0: F response, Active*, Active
// - Ten-bit fill count split, underflow, overflow flags
// - Partial last byte bits and missing parity
// - First collision byte and bit position recorded
// - Bit 0 marks collision on parity bit
// - Four-bit ISO-A passive target state code
// - Thirteen-bit byte count, upper eight first
// - Three extra bits after last full byte
// - Running flags for four internal timers
// - Bit rate result bits 5:4, converter value
// - Timer/field register at 1Bh, bits 7,6
`timescale 1ns/1ps
module nis_status_regs
  import nis_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [7:0] main_irq_value,
  input wire nis_events_t events,
  input wire nis_status_t status,
  output nis_config_t config_out,
  output logic main_irq_read
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (ADDR_WIDTH < 8) begin
      $error("nis_status_regs: ADDR_WIDTH must be at least 8");
    end
    if (NIS_FILL_MAX > 1023) begin
      $error("nis_status_regs: fill limit does not fit ten bits");
    end
    if (NIS_TX_LEN_MAX > 8191) begin
      $error("nis_status_regs: byte count limit exceeds thirteen bits");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    NIS_BUS_IDLE = 2'b00,
    NIS_BUS_ANSWER = 2'b01
  } nis_bus_state_t;

  typedef struct packed {
    nis_bus_state_t bus;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
    logic main_read;
    logic [7:0] tx_len_high;
    logic [7:0] tx_len_low;
    logic [7:0] tune_a;
    logic [7:0] tune_b;
    logic [7:0] tx_driver;
    logic [9:0] fill_count;
    logic [7:0] fill_flags;
    logic [7:0] collision;
    logic [3:0] target_state;
    logic [7:0] bitrate_timer;
    logic [7:0] converter;
  } nis_state_t;

  nis_state_t state_q;
  nis_state_t state_d;

  logic [7:0] tf_set;
  logic [7:0] ew_set;
  logic [7:0] pt_set;
  logic [7:0] tf_flags;
  logic [7:0] ew_flags;
  logic [7:0] pt_flags;
  logic [7:0] word_addr;
  logic [7:0] read_byte;
  logic mapped;
  logic writable;
  logic read_taken;
  logic tf_clear;
  logic ew_clear;
  logic pt_clear;

  // ---------------------------------------------------------------
  // Event bit assembly
  // ---------------------------------------------------------------
  assign tf_set = {events.direct_cmd_done,
                   events.no_response_expired,
                   events.general_timer_expired,
                   events.field_on,
                   events.field_off,
                   events.collision_in_avoidance,
                   events.guard_time_done,
                   events.bitrate_recognised};

  assign ew_set = {events.crc_error,
                   events.parity_error,
                   events.soft_framing_irq,
                   events.hard_framing_irq,
                   events.wakeup_timer_irq,
                   events.amplitude_wake,
                   events.phase_wake,
                   1'b0};

  assign pt_set = {events.peer_wait_timeout_irq,
                   events.slot_pool_low_irq,
                   events.active_field_on,
                   events.auto_response_sent,
                   events.f_target_active_irq,
                   1'b0,
                   events.a_target_active_star_irq,
                   events.a_target_active_irq};

  // ---------------------------------------------------------------
  // Sticky flag registers
  // ---------------------------------------------------------------
  // Clear strobes come from the taking edge of a read, see below
  nis_flag_reg #(
    .WIDTH(8)
  ) u_timer_field (
    .mclk(mclk),
    .reset_n(reset_n),
    .set_bits(tf_set),
    .clear(tf_clear),
    .flags(tf_flags)
  );

  nis_flag_reg #(
    .WIDTH(8)
  ) u_err_wake (
    .mclk(mclk),
    .reset_n(reset_n),
    .set_bits(ew_set),
    .clear(ew_clear),
    .flags(ew_flags)
  );

  nis_flag_reg #(
    .WIDTH(8)
  ) u_target (
    .mclk(mclk),
    .reset_n(reset_n),
    .set_bits(pt_set),
    .clear(pt_clear),
    .flags(pt_flags)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Offsets are not multiples of four: byte address is four times the index
  always_comb begin
    word_addr = avs_address[ADDR_WIDTH-1:2] > 8'hff ? 8'hff : 8'(avs_address[ADDR_WIDTH-1:2]);
    mapped = (avs_address[1:0] == 2'b00)
      && (word_addr >= NIS_OFS_MAIN_IRQ) && (word_addr <= NIS_OFS_TX_DRIVER);
    writable = 1'b0;
    read_byte = 8'h00;
    if (word_addr == NIS_OFS_MAIN_IRQ) begin
      read_byte = main_irq_value;
    end else if (word_addr == NIS_OFS_TIMER_FIELD) begin
      read_byte = tf_flags;
    end else if (word_addr == NIS_OFS_ERR_WAKE) begin
      read_byte = ew_flags;
    end else if (word_addr == NIS_OFS_PT_IRQ) begin
      read_byte = pt_flags;
    end else if (word_addr == NIS_OFS_FILL_LOW) begin
      read_byte = state_q.fill_count[7:0];
    end else if (word_addr == NIS_OFS_FILL_HIGH) begin
      read_byte = {state_q.fill_count[9:8], state_q.fill_flags[5:0]};
    end else if (word_addr == NIS_OFS_COLLISION) begin
      read_byte = state_q.collision;
    end else if (word_addr == NIS_OFS_TARGET_STATE) begin
      read_byte = {4'h0, state_q.target_state};
    end else if (word_addr == NIS_OFS_TX_LEN_HIGH) begin
      read_byte = state_q.tx_len_high;
      writable = 1'b1;
    end else if (word_addr == NIS_OFS_TX_LEN_LOW) begin
      read_byte = state_q.tx_len_low;
      writable = 1'b1;
    end else if (word_addr == NIS_OFS_BITRATE_TIMER) begin
      read_byte = state_q.bitrate_timer;
    end else if (word_addr == NIS_OFS_CONVERTER) begin
      read_byte = state_q.converter;
    end else if (word_addr == NIS_OFS_TUNE_A) begin
      read_byte = state_q.tune_a;
      writable = 1'b1;
    end else if (word_addr == NIS_OFS_TUNE_B) begin
      read_byte = state_q.tune_b;
      writable = 1'b1;
    end else if (word_addr == NIS_OFS_TX_DRIVER) begin
      read_byte = state_q.tx_driver;
      writable = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Clear-on-read strobes
  // ---------------------------------------------------------------
  // The clear acts on the edge that takes the read, the same edge that
  // captures the read data. An event on that edge is set after the clear
  // and survives; clearing one edge later would drop it unseen
  always_comb begin
    // Only a read that the bus takes this edge clears anything
    read_taken = (state_q.bus == NIS_BUS_IDLE) && avs_read && mapped;
    tf_clear = 1'b0;
    ew_clear = 1'b0;
    pt_clear = 1'b0;
    if (read_taken) begin
      // Main register read empties the error/wake-up flags
      if (word_addr == NIS_OFS_MAIN_IRQ) begin
        ew_clear = 1'b1;
      end else if (word_addr == NIS_OFS_TIMER_FIELD) begin
        tf_clear = 1'b1;
      end else if (word_addr == NIS_OFS_PT_IRQ) begin
        pt_clear = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.main_read = 1'b0;

    // Status snapshots except the collision position follow the core every cycle
    state_d.fill_count = status.fill_count > 10'(NIS_FILL_MAX) ?
      10'(NIS_FILL_MAX) : status.fill_count;
    state_d.fill_flags = {2'b00, status.fill_underflow, status.fill_overflow,
                          status.partial_byte_bits,
                          status.last_byte_parity_missing};
    // Position only updated on a valid anticollision collision
    if (status.collision_valid) begin
      state_d.collision = {status.collision_bytes, status.collision_bits,
                           status.collision_in_parity};
    end
    state_d.target_state = status.target_state;
    state_d.bitrate_timer = {2'b00, status.bitrate_code,
                             status.peer_field_wait_running,
                             status.general_timer_running,
                             status.no_response_running,
                             status.mask_receive_running};
    state_d.converter = status.converter_value;

    case (state_q.bus)
      NIS_BUS_IDLE: begin
        state_d.waitrequest = 1'b1;
        if (avs_read || avs_write) begin
          state_d.bus = NIS_BUS_ANSWER;
          state_d.waitrequest = 1'b0;
          state_d.response = mapped ? 2'b00 : 2'b11;
          state_d.readdata = avs_read && mapped ? {24'h00_0000, read_byte} : 32'h0000_0000;
          if (avs_read && mapped && (word_addr == NIS_OFS_MAIN_IRQ)) begin
            state_d.main_read = 1'b1;
          end
          // Read-only registers drop writes silently
          if (avs_write && mapped && writable && avs_byteenable[0]) begin
            if (word_addr == NIS_OFS_TX_LEN_HIGH) begin
              state_d.tx_len_high = avs_writedata[7:0];
            end else if (word_addr == NIS_OFS_TX_LEN_LOW) begin
              state_d.tx_len_low = avs_writedata[7:0];
            end else if (word_addr == NIS_OFS_TUNE_A) begin
              state_d.tune_a = avs_writedata[7:0];
            end else if (word_addr == NIS_OFS_TUNE_B) begin
              state_d.tune_b = avs_writedata[7:0];
            end else if (word_addr == NIS_OFS_TX_DRIVER) begin
              state_d.tx_driver = avs_writedata[7:0];
            end
          end
        end
      end
      NIS_BUS_ANSWER: begin
        state_d.bus = NIS_BUS_IDLE;
        state_d.waitrequest = 1'b1;
        state_d.response = 2'b00;
      end
      default: begin
        state_d.bus = NIS_BUS_IDLE;
        state_d.waitrequest = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.bus <= NIS_BUS_IDLE;
      state_q.waitrequest <= 1'b1;
      state_q.tx_len_high <= NIS_RST_TX_LEN;
      state_q.tx_len_low <= NIS_RST_TX_LEN;
      state_q.tune_a <= NIS_RST_TUNE_A;
      state_q.tune_b <= NIS_RST_TUNE_B;
      state_q.tx_driver <= NIS_RST_TX_DRIVER;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_readdata = state_q.readdata;
  assign avs_waitrequest = state_q.waitrequest;
  assign avs_response = state_q.response;
  assign main_irq_read = state_q.main_read;
  // Byte count upper eight bits sit in the first register
  assign config_out.tx_full_bytes = {state_q.tx_len_high, state_q.tx_len_low[7:3]};
  assign config_out.tx_extra_bits = state_q.tx_len_low[2:0];
  assign config_out.tuning_a = state_q.tune_a;
  assign config_out.tuning_b = state_q.tune_b;
  assign config_out.tx_driver = state_q.tx_driver;

endmodule : nis_status_regs

//--- tb/nis_sva.sv
// Concurrent checks on the ports of the status register bank
`timescale 1ns/1ps
module nis_sva
  import nis_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [7:0] main_irq_value,
  input wire nis_events_t events,
  input wire nis_status_t status,
  input wire nis_config_t config_out,
  input wire logic main_irq_read
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // Decoded request
  // ------------------------------------------------------------
  logic [7:0] a8;
  logic taken, rd_t, wr_t, mapped, ro;
  assign a8 = 8'(avs_address);
  assign taken = (avs_read || avs_write) && avs_waitrequest;
  assign rd_t = taken && avs_read;
  assign wr_t = taken && avs_write && avs_byteenable[0];
  assign mapped = (a8[1:0] == 2'b00) && (a8 >= 8'h68) && (a8 <= 8'ha0);
  // Status and display words, plus bit rate and converter
  assign ro = mapped && (a8 < 8'h88 || a8 == 8'h90 || a8 == 8'h94);
  a_unmapped_err: assert property (taken && !mapped |=> avs_response == 2'b11 && avs_readdata == '0)
    else $error("unmapped access not refused");
  a_ro_ignored: assert property (taken && avs_write && (ro || !mapped || !avs_byteenable[0]) |=> $stable(config_out))
    else $error("ignored write changed settings");
  a_main_pulse: assert property (rd_t && a8 == 8'h68 |=> main_irq_read ##1 !main_irq_read)
    else $error("main read pulse missing");
  a_main_data: assert property (rd_t && a8 == 8'h68 |=> avs_readdata[7:0] == $past(main_irq_value))
    else $error("main register value wrong");
  a_event_seen: assert property (rd_t && a8 == 8'h6c && $past(events.general_timer_expired, 2) |=> avs_readdata[5])
    else $error("timer expiry flag lost");
  a_read_clears: assert property ((rd_t && a8 == 8'h6c && events == '0) ##1 (events == '0) [*3] ##0 (rd_t && a8 == 8'h6c) |=> avs_readdata == '0)
    else $error("flags not cleared by read");
  a_tx_len_hi: assert property (wr_t && a8 == 8'h88 |=> config_out.tx_full_bytes[12:5] == $past(avs_writedata[7:0]))
    else $error("byte count upper bits wrong");
  a_tx_extra: assert property (wr_t && a8 == 8'h8c |=> config_out.tx_extra_bits == $past(avs_writedata[2:0]))
    else $error("extra bit count wrong");
  a_conv_show: assert property (rd_t && a8 == 8'h94 && $stable(status.converter_value) |=> avs_readdata[7:0] == $past(status.converter_value))
    else $error("converter value not shown");
  a_state_show: assert property (rd_t && a8 == 8'h84 && $stable(status.target_state) |=> avs_readdata[7:0] == {4'h0, $past(status.target_state)})
    else $error("target state not shown");
endmodule : nis_sva

//--- tb/nis_host.sv
// Host-side Avalon-MM master model issuing register accesses
`timescale 1ns/1ps
module nis_host #(
  parameter int AW = 8
) (
  input wire logic mclk,
  output logic [AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
  end
  // ------------------------------------------------------------
  // One bus access, held until waitrequest is seen low
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
    rd = 'x;
    rsp = 'x;
    @(posedge mclk);
    avs_address <= AW'({idx, 2'b00});
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    // Answer taken at once, never left pending
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines must not keep the old value
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask : acc
endmodule : nis_host

//--- tb/tb.sv
// Self-checking bench for the NFC status register bank
`timescale 1ns/1ps
module tb;
  import nis_pkg::*;
  localparam int AW = 8;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [AW-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, main_irq_read;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, rsp;
  logic [7:0] main_irq_value = 8'h00;
  nis_events_t events = '0;
  nis_status_t status = '0;
  nis_config_t config_out;
  logic [3:0] st [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd};
  int failures = 0;
  int tests_run = 0;
  always #20 mclk = ~mclk;
  nis_host #(.AW(AW)) host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response));
  nis_status_regs #(.ADDR_WIDTH(AW)) dut (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .main_irq_value(main_irq_value), .events(events),
    .status(status), .config_out(config_out), .main_irq_read(main_irq_read));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string m);
    host.acc(1'b0, idx, 8'h00, 4'h1, rd, rsp);
    chk(32'(rsp), 32'h0000_0000, m);
    chk(rd, exp, m);
  endtask : rdc
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.acc(1'b1, idx, d, 4'hf, rd, rsp);
  endtask : wr
  task automatic pulse(input int k);
    logic [21:0] ev;
    ev = '0;
    ev[k] = 1'b1;
    @(posedge mclk);
    events <= nis_events_t'(ev);
    @(posedge mclk);
    events <= '0;
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc(8'h22, 32'h0000_0000, "len hi rst");
    rdc(8'h23, 32'h0000_0000, "len lo rst");
    rdc(8'h26, 32'h0000_0080, "tune a rst");
    rdc(8'h27, 32'h0000_0080, "tune b rst");
    rdc(8'h28, 32'h0000_0070, "driver rst");
    rdc(8'h1d, 32'h0000_0000, "pt rst");
  endtask : t_reset
  task automatic t_rw();
    wr(8'h22, 8'hff);
    wr(8'h23, 8'hfd);
    chk(32'(config_out.tx_full_bytes), 32'h0000_1fff, "max len");
    chk(32'(config_out.tx_extra_bits), 32'h0000_0005, "extra");
    rdc(8'h23, 32'h0000_00fd, "len lo rb");
    // Lane 0 disabled, so nothing may land
    host.acc(1'b1, 8'h26, 8'h11, 4'h0, rd, rsp);
    rdc(8'h26, 32'h0000_0080, "be off");
    wr(8'h26, 8'h3c);
    wr(8'h27, 8'hc3);
    wr(8'h28, 8'h5a);
    chk(32'({config_out.tuning_a, config_out.tuning_b, config_out.tx_driver}), 32'h003c_c35a, "cfg");
    wr(8'h23, 8'h00);
    chk(32'(config_out.tx_extra_bits), 32'h0000_0000, "whole bytes");
  endtask : t_rw
  task automatic t_refuse();
    pulse(19);
    wr(8'h1b, 8'h00);
    wr(8'h24, 8'hff);
    rdc(8'h24, 32'h0000_0000, "ro bitrate");
    rdc(8'h1b, 32'h0000_0020, "pending kept");
    host.acc(1'b0, 8'h30, 8'h00, 4'h1, rd, rsp);
    chk(32'(rsp), 32'h0000_0003, "unmapped rsp");
    chk(rd, 32'h0000_0000, "unmapped data");
  endtask : t_refuse
  task automatic t_timer();
    for (int b = 0; b < 8; b++) begin
      pulse(14 + b);
      rdc(8'h1b, 32'h0000_0001 << b, "timer flag");
      rdc(8'h1b, 32'h0000_0000, "timer clr");
    end
  endtask : t_timer
  task automatic t_err();
    for (int b = 1; b < 8; b++)
      pulse(6 + b);
    rdc(8'h1c, 32'h0000_00fe, "err wake");
    main_irq_value <= 8'h96;
    rdc(8'h1a, 32'h0000_0096, "main");
    rdc(8'h1c, 32'h0000_0000, "err clr");
  endtask : t_err
  task automatic t_pt();
    for (int b = 0; b < 8; b++) begin
      if (b == 2)
        continue;
      pulse(b > 2 ? b - 1 : b);
      rdc(8'h1d, 32'h0000_0001 << b, "pt flag");
      rdc(8'h1d, 32'h0000_0000, "pt clr");
    end
  endtask : t_pt
  task automatic t_race();
    fork
      rdc(8'h1b, 32'h0000_0000, "race rd");
      begin
        // Event lands on the edge that takes the read
        repeat (1) @(posedge mclk);
        events <= nis_events_t'(22'h10_0000);
        @(posedge mclk);
        events <= '0;
      end
    join
    rdc(8'h1b, 32'h0000_0040, "race kept");
  endtask : t_race
  task automatic t_status();
    status <= nis_status_t'({10'h200, 1'b1, 1'b0, 3'h5, 1'b1, 1'b1, 4'ha, 3'h5, 1'b1,
      4'h0, 2'h2, 4'ha, 8'hc7});
    @(posedge mclk);
    rdc(8'h1e, 32'h0000_0000, "fill lo");
    rdc(8'h1f, 32'h0000_00ab, "fill hi");
    rdc(8'h20, 32'h0000_00ab, "collision");
    rdc(8'h24, 32'h0000_002a, "timers rate");
    rdc(8'h25, 32'h0000_00c7, "converter");
    status.collision_valid <= 1'b0;
    status.collision_bytes <= 4'h3;
    status.collision_in_parity <= 1'b0;
    @(posedge mclk);
    rdc(8'h20, 32'h0000_00ab, "coll held");
    status.collision_valid <= 1'b1;
    @(posedge mclk);
    rdc(8'h20, 32'h0000_003a, "coll data bit");
    for (int i = 0; i < 9; i++) begin
      status.target_state <= st[i];
      @(posedge mclk);
      rdc(8'h21, 32'(st[i]), "pt state");
    end
  endtask : t_status
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_rw();
    t_refuse();
    t_timer();
    t_err();
    t_pt();
    t_race();
    t_status();
    print_verdict();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    $display("CHECK FAILED %0t watchdog", $time);
    print_verdict();
  end
endmodule : tb
bind nis_status_regs nis_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.mclk(mclk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .main_irq_value(main_irq_value), .events(events),
  .status(status), .config_out(config_out), .main_irq_read(main_irq_read));
